// File: hdl/fsvrop_check.sv
`timescale 1ns/10ps
`default_nettype none

`include "fsvrop_defs.svh"

// Launch-time parameter check for the three commands
module fsvrop_check #(
  parameter logic [17:0] ARR_LO = `FSVROP_PARRAY_LO,
  parameter logic [17:0] ARR_HI = `FSVROP_PARRAY_HI
) (
  // Command parameters
  input  wire logic [15:0] cmdWord0,
  input  wire logic [15:0] cmdWord1,
  input  wire logic [15:0] cmdWord2,
  input  wire logic [2:0]  cmdIndex,
  // Mode and protection
  input  wire logic        modeVerifyOk,
  input  wire logic        modeReadOk,
  input  wire logic        modeProgOk,
  input  wire logic [17:0] protLo,
  input  wire logic [17:0] protHi,
  input  wire logic        protEn,
  // Result
  output logic             validCmd,
  output logic             access_error_flag,
  output logic             protErr
);

  logic [7:0]  code;
  logic [17:0] gAddr;
  logic [18:0] lastByte;
  logic        alignBad;
  logic        rangeBad;
  logic        crossBad;

  assign code  = cmdWord0[15:8];
  assign gAddr = {cmdWord0[1:0], cmdWord1};
  assign alignBad = gAddr[2:0] != 3'h0; // see [RQ4]
  assign rangeBad = (gAddr < ARR_LO) || (gAddr > ARR_HI); // see [RQ6]
  // Last byte of the section; a zero count checks nothing
  assign lastByte = {1'b0, gAddr} + {cmdWord2, 3'h0} - 19'h1;
  assign crossBad = (cmdWord2 != 16'h0) &&
                    (lastByte[18:17] != {1'b0, gAddr[17]}); // see [RQ5]

  always_comb begin
    validCmd = 1'b1;
    access_error_flag   = 1'b0;
    protErr  = 1'b0;
    case (code)
      `FSVROP_CMD_VERIFY_SECTION: begin
        access_error_flag = (cmdIndex != `FSVROP_IDX_VERIFY) || !modeVerifyOk || // see [RQ3] see [RQ7]
                 alignBad || rangeBad || crossBad;
      end
      `FSVROP_CMD_READ_ONCE: begin
        access_error_flag = (cmdIndex != `FSVROP_IDX_READ) || !modeReadOk || // see [RQ12] see [RQ7]
                 (cmdWord1 >= `FSVROP_ONCE_PHRASES); // see [RQ13]
      end
      `FSVROP_CMD_PROGRAM: begin
        access_error_flag  = (cmdIndex != `FSVROP_IDX_PROG) || !modeProgOk || // see [RQ18] see [RQ7]
                  alignBad || rangeBad;
        protErr = !access_error_flag && protEn && (gAddr >= protLo) && (gAddr <= protHi); // see [RQ19]
      end
      default: begin
        validCmd = 1'b0;
        access_error_flag   = 1'b1;
      end
    endcase
  end

endmodule

`default_nettype wire

// File: hdl/fsvrop_defs.svh
`ifndef FSVROP_DEFS_SVH
`define FSVROP_DEFS_SVH

// Command codes held in index 000 high byte
`define FSVROP_CMD_VERIFY_SECTION 8'h03
`define FSVROP_CMD_READ_ONCE      8'h04
`define FSVROP_CMD_PROGRAM        8'h06

// Index value required at launch per command
`define FSVROP_IDX_VERIFY 3'h2
`define FSVROP_IDX_READ   3'h1
`define FSVROP_IDX_PROG   3'h5

// One-time field geometry
`define FSVROP_ONCE_PHRASES 16'h0008

// Section boundary size, bytes (128 Kbyte)
`define FSVROP_SECTION_BYTES 18'h20000

// Program-array window, default valid region of the 18-bit map
`define FSVROP_PARRAY_LO 18'h30000
`define FSVROP_PARRAY_HI 18'h3ffff

// Erased phrase word pattern
`define FSVROP_ERASED_WORD 16'hffff

`endif

// File: hdl/fsvrop_pkg.sv
package fsvrop_pkg;

  typedef enum logic [1:0] {
    FSVROP_OP_VERIFY,
    FSVROP_OP_READ,
    FSVROP_OP_PROG
  } fsvrop_op_t;

  // Array port request bundle
  typedef struct packed {
    logic        rdReq;
    logic        wrReq;
    logic        once;
    logic [17:0] addr;
    logic [63:0] wrData;
  } fsvrop_arr_req_t;

  // Array port answer bundle
  typedef struct packed {
    logic        ack;
    logic        err;
    logic        uncorr;
    logic [63:0] rdData;
  } fsvrop_arr_rsp_t;

  // Status flags
  typedef struct packed {
    logic accessErr;
    logic protViol;
    logic verifyErr;
    logic verifyUncorr;
    logic singleFault;
    logic doubleFault;
  } fsvrop_status_t;

endpackage

// File: hdl/fsvrop_seq.sv
`timescale 1ns/10ps
`default_nettype none

`include "fsvrop_defs.svh"

// What this block does
// [RQ1] Section verify: code 03 plus addr high, index1 addr low, index2 count.
// [RQ2] Section verify checks every phrase erased, then sets complete flag.
// [RQ3] Section verify launched with index other than 010 is an access error.
// [RQ4] Verify and program reject phrase addresses with nonzero low three bits.
// [RQ5] Section verify crossing a 128 Kbyte boundary is an access error.
// [RQ6] Verify and program reject addresses outside the program array.
// [RQ7] Any command launched in a mode forbidding it is an access error.
// [RQ8] Verify and read-once set error and uncorrectable flags on read faults.
// [RQ9] One-time field holds 64 bytes as 8 phrases in info region.
// [RQ10] Read-once: code 04, index1 phrase 0..7, results go to indices 2..5.
// [RQ11] Read-once fetches phrase into result registers, then sets complete flag.
// [RQ12] Read-once launched with index other than 001 is an access error.
// [RQ13] Read-once with phrase index out of range is an access error.
// [RQ14] Program-array reads during read-once return invalid data.
// [RQ15] Software must not run read-once from the block holding the field.
// [RQ16] Program: code 06 plus addr high, index1 addr low, indices 2..5 data.
// [RQ17] Program writes four words, reads back to verify, then completes.
// [RQ18] Program launched with index other than 101 is an access error.
// [RQ19] Program into a protected region sets the protection violation flag.
// [RQ20] Program read-back faults set error and uncorrectable flags.
// [RQ21] Software programs only erased phrases, never cumulatively.
// [RQ22] Software clears pending error flags before a new command sequence.
// [RQ23] Array read during a command returns invalid data, sets both fault flags. Code sets them only if neither is already set.
// [RQ24] Launch-time errors skip array work and complete at once.
module fsvrop_seq #(
  parameter logic [17:0] ARR_LO = `FSVROP_PARRAY_LO,
  parameter logic [17:0] ARR_HI = `FSVROP_PARRAY_HI
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Command object access
  input  wire logic                     cobWrEn,
  input  wire logic [15:0]              cobWrData,
  input  wire logic                     idxWrEn,
  input  wire logic [2:0]               idxWrData,
  output logic [2:0]                    commandObjectIndex,
  output logic [15:0]                   cobRdData,
  // Launch and flag clearing (write-one-to-clear)
  input  wire logic                     launch,
  input  wire logic                     clrAccessErr,
  input  wire logic                     clrProtViol,
  input  wire logic                     clrSingleFault,
  input  wire logic                     clrDoubleFault,
  // Mode and protection configuration
  input  wire logic                     modeVerifyOk,
  input  wire logic                     modeReadOk,
  input  wire logic                     modeProgOk,
  input  wire logic                     protEn,
  input  wire logic [17:0]              protLo,
  input  wire logic [17:0]              protHi,
  // Status
  output logic                          commandCompleteFlag,
  output fsvrop_pkg::fsvrop_status_t    flashStatusRegister,
  // CPU reads of the program array
  input  wire logic                     cpuRdEn,
  input  wire logic [63:0]              cpuRdArray,
  output logic [63:0]                   cpuRdData,
  // Flash array port
  output fsvrop_pkg::fsvrop_arr_req_t   arrReq,
  input  wire fsvrop_pkg::fsvrop_arr_rsp_t arrRsp
);

  typedef enum logic [2:0] {
    FSVROP_IDLE,
    FSVROP_ISSUE,
    FSVROP_WAIT,
    FSVROP_PWRITE,
    FSVROP_PVERIFY
  } fsvrop_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Command object registers

  logic [15:0]               cob_q [0:5];
  logic [2:0]                idx_q;
  fsvrop_state_t             state_q;
  fsvrop_pkg::fsvrop_op_t    op_q;
  logic [17:0]               addr_q;
  logic [15:0]               remain_q;
  logic                      command_complete_flag_q;
  fsvrop_pkg::fsvrop_status_t stat_q;
  logic [63:0]               cpuRd_q;
  logic                      validCmd;
  logic                      chkAcc;
  logic                      chkProt;
  logic                      rdBusy;
  logic                      startOk;
  logic                      rdDone;
  logic                      rdFail;
  logic [63:0]               progData;

  // Launch is taken only while idle with the complete flag set
  assign startOk = launch && command_complete_flag_q && (state_q == FSVROP_IDLE);

  fsvrop_check #(
    .ARR_LO (ARR_LO),
    .ARR_HI (ARR_HI)
  ) u_check (
    .cmdWord0     (cob_q[0]),
    .cmdWord1     (cob_q[1]),
    .cmdWord2     (cob_q[2]),
    .cmdIndex     (idx_q),
    .modeVerifyOk (modeVerifyOk),
    .modeReadOk   (modeReadOk),
    .modeProgOk   (modeProgOk),
    .protLo       (protLo),
    .protHi       (protHi),
    .protEn       (protEn),
    .validCmd     (validCmd),
    .access_error_flag       (chkAcc),
    .protErr      (chkProt)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= 3'h0;
    end else if (idxWrEn && command_complete_flag_q) begin
      idx_q <= idxWrData;
    end
  end

  // Words written by software, or the read-once result words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 6; i++) begin
        cob_q[i] <= 16'h0;
      end
    end else if (state_q == FSVROP_WAIT && op_q == fsvrop_pkg::FSVROP_OP_READ && arrRsp.ack) begin
      cob_q[2] <= arrRsp.rdData[63:48]; // see [RQ11] see [RQ10]
      cob_q[3] <= arrRsp.rdData[47:32];
      cob_q[4] <= arrRsp.rdData[31:16];
      cob_q[5] <= arrRsp.rdData[15:0];
    end else if (cobWrEn && command_complete_flag_q && idx_q <= 3'h5) begin
      cob_q[idx_q] <= cobWrData;
    end
  end

  assign commandObjectIndex = idx_q;
  assign cobRdData          = (idx_q <= 3'h5) ? cob_q[idx_q] : 16'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  assign rdDone   = arrRsp.ack;
  assign rdFail   = arrRsp.err || arrRsp.uncorr;
  assign progData = {cob_q[2], cob_q[3], cob_q[4], cob_q[5]}; // see [RQ16]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= FSVROP_IDLE;
      op_q     <= fsvrop_pkg::FSVROP_OP_VERIFY;
      addr_q   <= 18'h0;
      remain_q <= 16'h0;
      command_complete_flag_q   <= 1'b1;
    end else begin
      case (state_q)
        FSVROP_IDLE: begin
          if (startOk) begin
            command_complete_flag_q   <= 1'b0;
            addr_q   <= {cob_q[0][1:0], cob_q[1]}; // see [RQ1]
            remain_q <= cob_q[2];
            state_q  <= FSVROP_ISSUE;
            case (cob_q[0][15:8])
              `FSVROP_CMD_READ_ONCE: op_q <= fsvrop_pkg::FSVROP_OP_READ;
              `FSVROP_CMD_PROGRAM:   op_q <= fsvrop_pkg::FSVROP_OP_PROG;
              default:               op_q <= fsvrop_pkg::FSVROP_OP_VERIFY;
            endcase
          end
        end
        FSVROP_ISSUE: begin
          if (chkAcc || chkProt || !validCmd) begin
            state_q <= FSVROP_IDLE; // see [RQ24]
            command_complete_flag_q  <= 1'b1;
          end else if (op_q == fsvrop_pkg::FSVROP_OP_PROG) begin
            state_q <= FSVROP_PWRITE;
          end else if (op_q == fsvrop_pkg::FSVROP_OP_VERIFY && remain_q == 16'h0) begin
            state_q <= FSVROP_IDLE;
            command_complete_flag_q  <= 1'b1;
          end else begin
            state_q <= FSVROP_WAIT;
          end
        end
        FSVROP_WAIT: begin
          if (rdDone) begin
            if (op_q == fsvrop_pkg::FSVROP_OP_VERIFY && remain_q > 16'h1) begin
              remain_q <= remain_q - 16'h1; // see [RQ2]
              addr_q   <= addr_q + 18'h8;
            end else begin
              state_q <= FSVROP_IDLE;
              command_complete_flag_q  <= 1'b1;
            end
          end
        end
        FSVROP_PWRITE: begin
          if (rdDone) begin
            state_q <= FSVROP_PVERIFY;
          end
        end
        FSVROP_PVERIFY: begin
          if (rdDone) begin
            state_q <= FSVROP_IDLE; // see [RQ17]
            command_complete_flag_q  <= 1'b1;
          end
        end
        default: begin
          state_q <= FSVROP_IDLE;
          command_complete_flag_q  <= 1'b1;
        end
      endcase
    end
  end

  assign commandCompleteFlag = command_complete_flag_q;

  // Array requests are held as levels until the array answers
  always_comb begin
    arrReq        = '0;
    arrReq.addr   = addr_q;
    arrReq.wrData = progData;
    case (state_q)
      FSVROP_WAIT: begin
        arrReq.rdReq = 1'b1;
        if (op_q == fsvrop_pkg::FSVROP_OP_READ) begin
          arrReq.once = 1'b1; // see [RQ9]
          arrReq.addr = {cob_q[1][14:0], 3'h0};
        end
      end
      FSVROP_PWRITE: begin
        arrReq.wrReq = 1'b1;
      end
      FSVROP_PVERIFY: begin
        arrReq.rdReq = 1'b1;
      end
      default: begin
        arrReq.rdReq = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; a hardware set wins over a clear in the same cycle

  logic erasedBad;
  logic verBad;
  logic chkEnd;

  assign erasedBad = (op_q == fsvrop_pkg::FSVROP_OP_VERIFY) &&
                     (arrRsp.rdData != {4{`FSVROP_ERASED_WORD}});
  assign verBad    = arrRsp.rdData != progData;
  assign chkEnd    = (state_q == FSVROP_ISSUE);
  assign rdBusy    = !command_complete_flag_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q.accessErr <= 1'b0;
      stat_q.protViol  <= 1'b0;
    end else begin
      if (chkEnd && (chkAcc || !validCmd)) begin
        stat_q.accessErr <= 1'b1; // see [RQ3] see [RQ12] see [RQ18]
      end else if (clrAccessErr) begin
        stat_q.accessErr <= 1'b0;
      end
      if (chkEnd && chkProt) begin
        stat_q.protViol <= 1'b1; // see [RQ19]
      end else if (clrProtViol) begin
        stat_q.protViol <= 1'b0;
      end
    end
  end

  // Verify flags restart at each accepted launch, then accumulate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q.verifyErr    <= 1'b0;
      stat_q.verifyUncorr <= 1'b0;
    end else if (startOk) begin
      stat_q.verifyErr    <= 1'b0;
      stat_q.verifyUncorr <= 1'b0;
    end else if (rdDone && (state_q == FSVROP_WAIT || state_q == FSVROP_PVERIFY)) begin
      if (rdFail || erasedBad || (state_q == FSVROP_PVERIFY && verBad)) begin
        stat_q.verifyErr <= 1'b1; // see [RQ8] see [RQ20]
      end
      if (arrRsp.uncorr) begin
        stat_q.verifyUncorr <= 1'b1; // see [RQ8] see [RQ20]
      end
    end
  end

  // A CPU array read while busy yields invalid data, and sets both fault flags only if neither is already set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q.singleFault <= 1'b0;
      stat_q.doubleFault <= 1'b0;
    end else begin
      if (cpuRdEn && rdBusy && !stat_q.singleFault && !stat_q.doubleFault) begin
        stat_q.singleFault <= 1'b1; // see [RQ23]
        stat_q.doubleFault <= 1'b1;
      end else begin
        if (clrSingleFault) begin
          stat_q.singleFault <= 1'b0;
        end
        if (clrDoubleFault) begin
          stat_q.doubleFault <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuRd_q <= 64'h0;
    end else if (cpuRdEn) begin
      cpuRd_q <= rdBusy ? {4{`FSVROP_ERASED_WORD}} : cpuRdArray; // see [RQ14] see [RQ23]
    end
  end

  assign cpuRdData           = cpuRd_q;
  assign flashStatusRegister = stat_q;

endmodule

`default_nettype wire

// File: tb/fsvrop_properties.sv
`timescale 1ns/10ps
`default_nettype none

module fsvrop_properties (
  // Clock and reset
  input wire logic                         clk,
  input wire logic                         rst_n,
  // Command side
  input wire logic                         cobWrEn,
  input wire logic [15:0]                  cobWrData,
  input wire logic [2:0]                   commandObjectIndex,
  input wire logic                         launch,
  input wire logic                         modeProgOk,
  input wire logic                         commandCompleteFlag,
  input wire fsvrop_pkg::fsvrop_status_t   flashStatusRegister,
  // CPU and array side
  input wire logic                         cpuRdEn,
  input wire logic [63:0]                  cpuRdData,
  input wire fsvrop_pkg::fsvrop_arr_req_t  arrReq,
  input wire fsvrop_pkg::fsvrop_arr_rsp_t  arrRsp
);
  logic [7:0] cmdCode_q;
  logic       idxBad;

  // Shadow of the command code so launch checks know which command runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdCode_q <= 8'h00;
    end else if (cobWrEn && commandCompleteFlag && commandObjectIndex == 3'h0) begin
      cmdCode_q <= cobWrData[15:8];
    end
  end

  assign idxBad = (cmdCode_q == 8'h03 && commandObjectIndex != 3'h2) ||
                  (cmdCode_q == 8'h04 && commandObjectIndex != 3'h1) ||
                  (cmdCode_q == 8'h06 && commandObjectIndex != 3'h5);

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence accepted;
    launch && commandCompleteFlag;
  endsequence

  sequence writeDone;
    arrReq.wrReq && arrRsp.ack;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  launch_busy_a: assert property (accepted |=> !commandCompleteFlag)
    else $error("complete flag did not fall after launch");
  cmd_index_a: assert property (accepted and idxBad |-> ##[1:3] flashStatusRegister.accessErr)
    else $error("wrong index at launch not flagged");
  mode_deny_a: assert property (accepted and cmdCode_q == 8'h06 && !modeProgOk
    |-> ##[1:3] flashStatusRegister.accessErr)
    else $error("program in forbidden mode not flagged");
  error_no_array_a: assert property ($rose(flashStatusRegister.accessErr) ||
    $rose(flashStatusRegister.protViol) |-> commandCompleteFlag && !arrReq.rdReq && !arrReq.wrReq)
    else $error("launch error did not complete at once");
  write_hold_a: assert property (arrReq.wrReq && !arrRsp.ack
    |=> arrReq.wrReq && $stable(arrReq.addr) && $stable(arrReq.wrData))
    else $error("write request dropped before ack");
  read_back_a: assert property (writeDone |=> arrReq.rdReq && $stable(arrReq.addr) && !commandCompleteFlag)
    else $error("no read back after write");
  once_addr_a: assert property (arrReq.rdReq && arrReq.once
    |-> arrReq.addr[17:6] == 12'h000 && arrReq.addr[2:0] == 3'h0)
    else $error("one-time read outside field");
  read_err_a: assert property (arrReq.rdReq && arrRsp.ack && arrRsp.err
    |-> ##[1:2] flashStatusRegister.verifyErr)
    else $error("read error not flagged");
  read_uncorr_a: assert property (arrReq.rdReq && arrRsp.ack && arrRsp.uncorr
    |-> ##[1:2] flashStatusRegister.verifyUncorr)
    else $error("uncorrectable error not flagged");
  busy_read_a: assert property (cpuRdEn && !commandCompleteFlag
    |=> cpuRdData == 64'hffff_ffff_ffff_ffff)
    else $error("busy read returned array data");
  fault_set_a: assert property (cpuRdEn && !commandCompleteFlag && !flashStatusRegister.singleFault
    && !flashStatusRegister.doubleFault |=> flashStatusRegister.singleFault
    && flashStatusRegister.doubleFault)
    else $error("busy read did not set fault flags");
endmodule

bind fsvrop_seq fsvrop_properties u_props (
  .clk(clk), .rst_n(rst_n), .cobWrEn(cobWrEn), .cobWrData(cobWrData),
  .commandObjectIndex(commandObjectIndex), .launch(launch), .modeProgOk(modeProgOk),
  .commandCompleteFlag(commandCompleteFlag), .flashStatusRegister(flashStatusRegister),
  .cpuRdEn(cpuRdEn), .cpuRdData(cpuRdData), .arrReq(arrReq), .arrRsp(arrRsp)
);

`default_nettype wire

// File: tb/tb_flash_section_verify_read_once_program.sv
`timescale 1ns/10ps
`default_nettype none

module tb_flash_section_verify_read_once_program;
  logic                        clk, rst_n, cobWrEn, idxWrEn, launch, clrAll, cpuRdEn;
  logic                        mVer, mRd, mPrg, protEn, cCF, errInj, uncInj, busyRd;
  logic [15:0]                 cobWrData, cobRdData;
  logic [2:0]                  idxWrData, curIdx;
  logic [17:0]                 protLo, protHi;
  logic [63:0]                 cpuRdArray, cpuRdData;
  logic [63:0]                 onceMem [8];
  logic [63:0]                 mem [logic [17:0]];
  fsvrop_pkg::fsvrop_status_t  stat;
  fsvrop_pkg::fsvrop_arr_req_t req;
  fsvrop_pkg::fsvrop_arr_rsp_t rsp;
  int                          errors, n_checks, cycles, acks, lat, waitCnt;

  fsvrop_seq uut (
    .clk(clk), .rst_n(rst_n), .cobWrEn(cobWrEn), .cobWrData(cobWrData),
    .idxWrEn(idxWrEn), .idxWrData(idxWrData), .commandObjectIndex(curIdx),
    .cobRdData(cobRdData), .launch(launch), .clrAccessErr(clrAll), .clrProtViol(clrAll),
    .clrSingleFault(clrAll), .clrDoubleFault(clrAll), .modeVerifyOk(mVer),
    .modeReadOk(mRd), .modeProgOk(mPrg), .protEn(protEn), .protLo(protLo), .protHi(protHi),
    .commandCompleteFlag(cCF), .flashStatusRegister(stat), .cpuRdEn(cpuRdEn),
    .cpuRdArray(cpuRdArray), .cpuRdData(cpuRdData), .arrReq(req), .arrRsp(rsp)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash array: acks after lat wait cycles, data line toggles every cycle unless a read ack loads it
  always @(negedge clk) begin
    rsp.rdData = ~rsp.rdData;
    if (rsp.ack || !(req.rdReq || req.wrReq)) begin
      rsp.ack = 1'b0;
      rsp.err = 1'b0;
      rsp.uncorr = 1'b0;
      waitCnt = 0;
    end else if (waitCnt < lat) begin
      waitCnt++;
    end else begin
      rsp.ack = 1'b1;
      acks++;
      rsp.err = errInj && req.rdReq;
      rsp.uncorr = uncInj && req.rdReq;
      if (req.wrReq) mem[req.addr] = req.wrData;
      else if (req.once) rsp.rdData = onceMem[req.addr[5:3]];
      else rsp.rdData = mem.exists(req.addr) ? mem[req.addr] : 64'hffff_ffff_ffff_ffff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic setIdx(logic [2:0] i);
    idxWrEn = 1'b1;
    idxWrData = i;
    @(negedge clk);
    idxWrEn = 1'b0;
  endtask

  task automatic wrWord(logic [2:0] i, logic [15:0] d);
    setIdx(i);
    cobWrEn = 1'b1;
    cobWrData = d;
    @(negedge clk);
    cobWrEn = 1'b0;
  endtask

  task automatic clr();
    clrAll = 1'b1;
    @(negedge clk);
    clrAll = 1'b0;
    chk("clear", stat, 6'h00);
  endtask

  task automatic run(logic [7:0] c, logic [17:0] a, logic [15:0] w2, logic [2:0] i);
    int n;
    wrWord(3'h0, {c, 6'h00, a[17:16]});
    wrWord(3'h1, a[15:0]);
    wrWord(3'h2, w2);
    wrWord(3'h3, 16'ha5a5);
    wrWord(3'h4, 16'h5a5a);
    wrWord(3'h5, 16'h0f0f);
    setIdx(i);
    acks = 0;
    launch = 1'b1;
    @(negedge clk);
    launch = 1'b0;
    chk("busy", cCF, 1'b0);
    if (busyRd) begin
      cpuRdEn = 1'b1;
      @(negedge clk);
      cpuRdEn = 1'b0;
      chk("busyRead", cpuRdData, 64'hffff_ffff_ffff_ffff);
    end
    for (n = 0; n < 300 && cCF !== 1'b1; n++) @(negedge clk);
    chk("done", cCF, 1'b1);
  endtask

  task automatic bad(logic [7:0] c, logic [17:0] a, logic [15:0] w2, logic [2:0] i,
                     logic [2:0] m, logic [5:0] e);
    {mVer, mRd, mPrg} = m;
    run(c, a, w2, i);
    chk("errStat", stat, e);
    chk("errAcks", acks, 0);
    {mVer, mRd, mPrg} = 3'h7;
    clr();
  endtask

  task automatic test_done();
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, cobWrEn, idxWrEn, launch, clrAll, cpuRdEn, errInj, uncInj, busyRd} = '0;
    {mVer, mRd, mPrg, protEn} = 4'hf;
    {cobWrData, idxWrData, rsp} = '0;
    {protLo, protHi} = {18'h38000, 18'h38fff};
    cpuRdArray = 64'h0123_4567_89ab_cdef;
    lat = 2;
    for (int k = 0; k < 8; k++) onceMem[k] = 64'hfedc_ba98_7654_3210 + 64'(k);
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    chk("rstDone", cCF, 1'b1);
    chk("rstStat", stat, 6'h00);
    chk("rstIdx", curIdx, 3'h0);
    // Each program targets a phrase never written before
    run(8'h06, 18'h30008, 16'h1111, 3'h5);
    chk("progStat", stat, 6'h00);
    chk("progMem", mem[18'h30008], 64'h1111_a5a5_5a5a_0f0f);
    chk("progAcks", acks, 2);
    cpuRdEn = 1'b1;
    @(negedge clk);
    cpuRdEn = 1'b0;
    chk("idleRead", cpuRdData, cpuRdArray);
    run(8'h03, 18'h30010, 16'h0004, 3'h2);
    chk("verClean", {stat, 8'(acks)}, {6'h00, 8'd4});
    run(8'h03, 18'h30000, 16'h0002, 3'h2);
    chk("verDirty", stat, 6'h08);
    run(8'h03, 18'h30000, 16'h0000, 3'h2);
    chk("verZero", {stat, 8'(acks)}, {6'h00, 8'd0});
    run(8'h03, 18'h3fff8, 16'h0001, 3'h2);
    chk("verEdge", {stat, 8'(acks)}, {6'h00, 8'd1});
    lat = 4;
    busyRd = 1'b1;
    // Bench issues read-once from outside the array, no code runs from the field
    run(8'h04, 18'h00007, 16'h0000, 3'h1);
    busyRd = 1'b0;
    chk("onceStat", stat, 6'h03);
    for (int k = 2; k < 6; k++) begin
      setIdx(3'(k));
      chk("onceWord", cobRdData, onceMem[7][16*(5-k) +: 16]);
    end
    clr();
    lat = 1;
    {errInj, uncInj} = 2'b11;
    run(8'h04, 18'h00000, 16'h0000, 3'h1);
    chk("onceFault", stat, 6'h0c);
    run(8'h06, 18'h30018, 16'h2222, 3'h5);
    chk("progFault", stat, 6'h0c);
    run(8'h03, 18'h30020, 16'h0001, 3'h2);
    chk("verFault", stat, 6'h0c);
    {errInj, uncInj} = 2'b00;
    bad(8'h03, 18'h30000, 16'h1, 3'h1, 3'h7, 6'h20);
    bad(8'h04, 18'h00000, 16'h0, 3'h2, 3'h7, 6'h20);
    bad(8'h06, 18'h30000, 16'h0, 3'h4, 3'h7, 6'h20);
    bad(8'h03, 18'h30004, 16'h1, 3'h2, 3'h7, 6'h20);
    bad(8'h06, 18'h30002, 16'h0, 3'h5, 3'h7, 6'h20);
    bad(8'h03, 18'h3fff8, 16'h2, 3'h2, 3'h7, 6'h20);
    bad(8'h03, 18'h10000, 16'h1, 3'h2, 3'h7, 6'h20);
    bad(8'h06, 18'h20000, 16'h0, 3'h5, 3'h7, 6'h20);
    bad(8'h04, 18'h00008, 16'h0, 3'h1, 3'h7, 6'h20);
    bad(8'h03, 18'h30000, 16'h1, 3'h2, 3'h3, 6'h20);
    bad(8'h04, 18'h00000, 16'h0, 3'h1, 3'h5, 6'h20);
    bad(8'h06, 18'h30000, 16'h0, 3'h5, 3'h6, 6'h20);
    bad(8'h06, 18'h38000, 16'h0, 3'h5, 3'h7, 6'h10);
    test_done();
  end
endmodule

`default_nettype wire
